// >>> core/aladp_top.sv
// datapath top for the add and AND instructions: work register, status flags,
// memory write-back and a small software register port.
// assumes the decoder presents the memory operand in the same cycle as the op
// strobe, and that the data memory takes a one-cycle write pulse.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module aladp_top
	import aladp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_op_valid,
	input wire aladp_op_t i_op_code,
	input wire logic [ALADP_AW-1:0] i_mem_addr,
	input wire logic [ALADP_DW-1:0] i_mem_rdata,
	input wire logic [ALADP_DW-1:0] i_imm,
	output logic o_mem_we,
	output logic [ALADP_AW-1:0] o_mem_addr,
	output logic [ALADP_DW-1:0] o_mem_wdata,
	output logic [ALADP_DW-1:0] o_work,
	output logic [3:0] o_flags,
	input wire logic [ALADP_RAW-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata
);
	aladp_alu_if alu_bus();

	logic [ALADP_DW-1:0] work_r;
	logic [ALADP_DW-1:0] work_nxt;
	logic [3:0] flags_r;
	logic [3:0] flags_nxt;
	logic mem_we_r;
	logic [ALADP_AW-1:0] mem_addr_r;
	logic [ALADP_DW-1:0] mem_wdata_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	wire sel_work;
	wire sel_flags;
	wire sw_work_wr;
	wire sw_flags_wr;
	wire op_to_work;
	wire [3:0] flags_op;

	assign alu_bus.op = i_op_code;
	assign alu_bus.opa = work_r;
	// immediate operand replaces the memory byte only for the immediate AND
	assign alu_bus.opb = (i_op_code == ALADP_OP_AND_ACC_IMM) ? i_imm : i_mem_rdata;

	aladp_alu u_alu (
		.bus(alu_bus.alu)
	);

	assign sel_work = (i_reg_addr == ALADP_REG_WORK);
	assign sel_flags = (i_reg_addr == ALADP_REG_FLAGS);
	assign sw_work_wr = i_reg_wr && sel_work;
	assign sw_flags_wr = i_reg_wr && sel_flags;
	assign op_to_work = i_op_valid && !alu_bus.to_mem;

	// arithmetic op rewrites all four flags, the AND forms only the zero flag
	assign flags_op = alu_bus.arith ?
		{alu_bus.signed_wrap, alu_bus.zero, alu_bus.half, alu_bus.carry} :
		{flags_r[ALADP_FLAG_SIGNED], alu_bus.zero,
			flags_r[ALADP_FLAG_HALF], flags_r[ALADP_FLAG_C]};

	// an instruction in the same cycle as a software write wins: the core's
	// own update must never be lost to a debug poke
	assign work_nxt = op_to_work ? alu_bus.res :
		((sw_work_wr && !i_op_valid) ? i_reg_wdata[ALADP_DW-1:0] : work_r);
	assign flags_nxt = i_op_valid ? flags_op :
		(sw_flags_wr ? i_reg_wdata[3:0] : flags_r);

	assign rdata_nxt = !i_reg_rd ? 32'h0000_0000 :
		sel_work ? {24'h00_0000, work_r} :
		sel_flags ? {28'h000_0000, flags_r} : 32'h0000_0000;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			work_r <= ALADP_WORK_RST;
			flags_r <= ALADP_FLAGS_RST;
		end else begin
			work_r <= work_nxt;
			flags_r <= flags_nxt;
		end
	end

	// memory write-back is a one-cycle pulse after the op is taken
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mem_we_r <= 1'b0;
			mem_addr_r <= 8'h00;
			mem_wdata_r <= 8'h00;
		end else begin
			mem_we_r <= i_op_valid && alu_bus.to_mem;
			if (i_op_valid && alu_bus.to_mem) begin
				mem_addr_r <= i_mem_addr;
				mem_wdata_r <= alu_bus.res;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign o_mem_we = mem_we_r;
	assign o_mem_addr = mem_addr_r;
	assign o_mem_wdata = mem_wdata_r;
	assign o_work = work_r;
	assign o_flags = flags_r;
	assign o_reg_rdata = rdata_r;

	property p_sum_mem;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_op_valid && i_op_code == ALADP_OP_SUM_MEM) |=>
			o_mem_flags_ok_sum($past(work_r), $past(i_mem_rdata), o_flags);
	endproperty
	a_sum_mem: assert property (p_sum_mem) else $error("sum flags wrong");

	function automatic logic o_mem_flags_ok_sum(input logic [7:0] a, input logic [7:0] b,
		input logic [3:0] f);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		return f[ALADP_FLAG_C] == s[8] && f[ALADP_FLAG_HALF] == h[4] &&
			f[ALADP_FLAG_Z] == (s[7:0] == 8'h00) &&
			f[ALADP_FLAG_SIGNED] == ((a[7] == b[7]) && (s[7] != a[7]));
	endfunction

	property p_sum_wb;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_op_valid && i_op_code == ALADP_OP_SUM_MEM) |=>
			o_mem_we && o_mem_addr == $past(i_mem_addr) &&
			o_mem_wdata == 8'($past(work_r) + $past(i_mem_rdata)) &&
			work_r == $past(work_r);
	endproperty
	a_sum_wb: assert property (p_sum_wb) else $error("sum not written back");

	property p_and_mem;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_op_valid && i_op_code == ALADP_OP_AND_ACC_MEM) |=>
			work_r == ($past(work_r) & $past(i_mem_rdata)) &&
			o_flags[1:0] == $past(flags_r[1:0]) && o_flags[3] == $past(flags_r[3]);
	endproperty
	a_and_mem: assert property (p_and_mem) else $error("and with memory wrong");

	property p_and_keep_mem;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_op_valid && (i_op_code == ALADP_OP_AND_ACC_MEM ||
			i_op_code == ALADP_OP_AND_ACC_IMM)) |=> !o_mem_we;
	endproperty
	a_and_keep_mem: assert property (p_and_keep_mem) else $error("memory touched");

	property p_and_imm;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_op_valid && i_op_code == ALADP_OP_AND_ACC_IMM) |=>
			work_r == ($past(work_r) & $past(i_imm)) &&
			o_flags[1:0] == $past(flags_r[1:0]);
	endproperty
	a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

	property p_conj_mem;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_op_valid && i_op_code == ALADP_OP_CONJ_MEM) |=>
			o_mem_we && o_mem_wdata == ($past(work_r) & $past(i_mem_rdata)) &&
			work_r == $past(work_r) ##1 !o_mem_we || $past(i_op_valid);
	endproperty
	a_conj_mem: assert property (p_conj_mem) else $error("and to memory wrong");

	property p_zero;
		@(posedge i_clk) disable iff (!i_rstn)
		i_op_valid |=> o_flags[ALADP_FLAG_Z] ==
			((o_mem_we ? o_mem_wdata : work_r) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	c_sum: cover property (@(posedge i_clk) disable iff (!i_rstn)
		i_op_valid && i_op_code == ALADP_OP_SUM_MEM ##1 o_flags[ALADP_FLAG_C]);
	c_and_zero: cover property (@(posedge i_clk) disable iff (!i_rstn)
		i_op_valid && i_op_code == ALADP_OP_AND_ACC_IMM ##1 o_flags[ALADP_FLAG_Z]);
	c_back2back: cover property (@(posedge i_clk) disable iff (!i_rstn)
		i_op_valid && i_op_code == ALADP_OP_CONJ_MEM ##1 i_op_valid);
endmodule // aladp_top

// >>> core/aladp_pkg.sv
// package of the add-and-logic datapath: opcodes, flag positions, register map.
// assumes a single 100 MHz clock shared by decoder, data memory and this block.
// Functional notes
// - sum_to_memory_op adds memory byte and work register, updates all four flags.
// - sum_to_memory_op writes the sum back to the addressed memory byte.
// - AND with memory forms work register AND memory byte, touches zero flag only.
// - AND forms targeting work register load it and leave memory unchanged.
// - AND with immediate ANDs work register with the constant, zero flag only.
// - conjunct_to_memory_op stores memory byte AND work register into that byte.
package aladp_pkg;
	localparam int ALADP_DW = 8;
	localparam int ALADP_AW = 8;
	localparam int ALADP_RAW = 8;

	typedef enum logic [1:0] {
		ALADP_OP_SUM_MEM = 2'b00,
		ALADP_OP_AND_ACC_MEM = 2'b01,
		ALADP_OP_AND_ACC_IMM = 2'b10,
		ALADP_OP_CONJ_MEM = 2'b11
	} aladp_op_t;

	// flag positions inside the status register
	localparam int ALADP_FLAG_C = 0;
	localparam int ALADP_FLAG_HALF = 1;
	localparam int ALADP_FLAG_Z = 2;
	localparam int ALADP_FLAG_SIGNED = 3;

	// register offsets (byte addresses) and reset values
	localparam logic [ALADP_RAW-1:0] ALADP_REG_WORK = 8'h00;
	localparam logic [ALADP_RAW-1:0] ALADP_REG_FLAGS = 8'h04;
	localparam logic [ALADP_DW-1:0] ALADP_WORK_RST = 8'h00;
	localparam logic [3:0] ALADP_FLAGS_RST = 4'h0;
endpackage

// >>> core/aladp_alu_if.sv
// connection between the datapath top and its combinational arithmetic unit.
// assumes both ends sit on the same clock; nothing here is registered.
`timescale 1ns/1ps
interface aladp_alu_if;
	import aladp_pkg::*;
	aladp_op_t op;
	logic [ALADP_DW-1:0] opa;
	logic [ALADP_DW-1:0] opb;
	logic [ALADP_DW-1:0] res;
	logic carry;
	logic half;
	logic signed_wrap;
	logic zero;
	logic to_mem;
	logic arith;
	modport top (output op, output opa, output opb,
		input res, input carry, input half, input signed_wrap, input zero,
		input to_mem, input arith);
	modport alu (input op, input opa, input opb,
		output res, output carry, output half, output signed_wrap, output zero,
		output to_mem, output arith);
endinterface

// >>> core/aladp_alu.sv
// combinational sum / AND unit with flag generation.
// assumes opa is the work register and opb the memory byte or immediate.
`timescale 1ns/1ps
module aladp_alu
	import aladp_pkg::*;
(
	aladp_alu_if.alu bus
);
	wire [ALADP_DW:0] sum_full;
	wire [4:0] sum_low;
	wire [ALADP_DW-1:0] conj;
	wire is_sum;

	assign is_sum = (bus.op == ALADP_OP_SUM_MEM);
	assign sum_full = {1'b0, bus.opa} + {1'b0, bus.opb};
	assign sum_low = {1'b0, bus.opa[3:0]} + {1'b0, bus.opb[3:0]};
	assign conj = bus.opa & bus.opb;
	assign bus.res = is_sum ? sum_full[ALADP_DW-1:0] : conj;
	assign bus.carry = sum_full[ALADP_DW];
	assign bus.half = sum_low[4];
	// signed wrap: operands agree in sign and the result does not
	assign bus.signed_wrap = (bus.opa[7] == bus.opb[7]) && (sum_full[7] != bus.opa[7]);
	assign bus.zero = (bus.res == 8'h00);
	assign bus.to_mem = is_sum || (bus.op == ALADP_OP_CONJ_MEM);
	assign bus.arith = is_sum;
endmodule // aladp_alu

// >>> bench/aladp_mem_model.sv
// data memory model standing in for the core's byte memory.
// assumes the datapath writes with a one-cycle pulse and reads combinationally.
`timescale 1ns/1ps
module aladp_mem_model
	import aladp_pkg::*;
(
	input wire logic i_clk,
	input wire logic [ALADP_AW-1:0] i_raddr,
	output logic [ALADP_DW-1:0] o_rdata,
	input wire logic i_we,
	input wire logic [ALADP_AW-1:0] i_waddr,
	input wire logic [ALADP_DW-1:0] i_wdata
);
	logic [ALADP_DW-1:0] mem [0:255];
	// no forwarding here: back-to-back ops on one address would read stale data
	assign o_rdata = mem[i_raddr];
	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end
endmodule // aladp_mem_model

// >>> bench/tb.sv
// self-checking bench of the add-and-logic datapath.
// assumes the memory model answers in the op cycle and flags are {sw,z,half,c}.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module tb;
	import aladp_pkg::*;
	logic i_clk = 0, i_rstn = 0, i_op_valid = 0, i_reg_wr = 0, i_reg_rd = 0;
	aladp_op_t i_op_code = ALADP_OP_SUM_MEM;
	logic [7:0] i_mem_addr = 8'h00, i_mem_rdata, i_imm = 8'h00, i_reg_addr = 8'h00;
	logic [31:0] i_reg_wdata = 32'h0000_0000, o_reg_rdata;
	logic o_mem_we;
	logic [7:0] o_mem_addr, o_mem_wdata, o_work;
	logic [3:0] o_flags;
	int n_errors = 0, tests_run = 0;
	aladp_top aladp_top_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_op_valid(i_op_valid),
		.i_op_code(i_op_code), .i_mem_addr(i_mem_addr), .i_mem_rdata(i_mem_rdata),
		.i_imm(i_imm), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
		.o_mem_wdata(o_mem_wdata), .o_work(o_work), .o_flags(o_flags),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
	aladp_mem_model aladp_mem_model_inst (.i_clk(i_clk), .i_raddr(i_mem_addr),
		.o_rdata(i_mem_rdata), .i_we(o_mem_we), .i_waddr(o_mem_addr),
		.i_wdata(o_mem_wdata));
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, o_reg_rdata)
		@(posedge i_clk);
		#1 `CHK("reg_rdata_idle", 32'h0000_0000, o_reg_rdata)
	endtask
	// one instruction, then judge work, flags and the write pulse in the answer cycle
	task automatic op_run(input aladp_op_t op, input logic [7:0] a, input logic [7:0] imm,
		input logic [7:0] ew, input logic [3:0] ef, input logic we, input logic [7:0] wd);
		logic [7:0] m0;
		m0 = aladp_mem_model_inst.mem[a];
		@(posedge i_clk);
		i_op_valid <= 1'b1;
		i_op_code <= op;
		i_mem_addr <= a;
		i_imm <= imm;
		@(posedge i_clk);
		i_op_valid <= 1'b0;
		#1 `CHK("work", ew, o_work)
		`CHK("flags", ef, o_flags)
		`CHK("mem_we", we, o_mem_we)
		if (we) begin
			`CHK("mem_addr", a, o_mem_addr)
			`CHK("mem_wdata", wd, o_mem_wdata)
		end
		@(posedge i_clk);
		#1 `CHK("mem_byte", (we ? wd : m0), aladp_mem_model_inst.mem[a])
	endtask
	task automatic t_reset;
		`CHK("work_rst", 8'h00, o_work)
		`CHK("flags_rst", 4'h0, o_flags)
		reg_rd(ALADP_REG_FLAGS, 32'h0000_0000);
		reg_wr(ALADP_REG_WORK, 32'h0000_007F);
		reg_rd(ALADP_REG_WORK, 32'h0000_007F);
		reg_wr(ALADP_REG_FLAGS, 32'h0000_000A);
		reg_rd(ALADP_REG_FLAGS, 32'h0000_000A);
		reg_rd(8'h08, 32'h0000_0000);
	endtask
	task automatic t_sum;
		aladp_mem_model_inst.mem[8'h10] = 8'h01;
		op_run(ALADP_OP_SUM_MEM, 8'h10, 8'h00, 8'h7F, 4'b1010, 1'b1, 8'h80);
		reg_wr(ALADP_REG_WORK, 32'h0000_0080);
		aladp_mem_model_inst.mem[8'h20] = 8'h80;
		op_run(ALADP_OP_SUM_MEM, 8'h20, 8'h00, 8'h80, 4'b1101, 1'b1, 8'h00);
	endtask
	task automatic t_and;
		reg_wr(ALADP_REG_WORK, 32'h0000_00F3);
		aladp_mem_model_inst.mem[8'h30] = 8'h3C;
		op_run(ALADP_OP_AND_ACC_MEM, 8'h30, 8'h00, 8'h30, 4'b1001, 1'b0, 8'h00);
		`CHK("mem_kept", 8'h3C, aladp_mem_model_inst.mem[8'h30])
		op_run(ALADP_OP_AND_ACC_IMM, 8'h30, 8'h0C, 8'h00, 4'b1101, 1'b0, 8'h00);
	endtask
	task automatic t_conj;
		reg_wr(ALADP_REG_WORK, 32'h0000_00A5);
		aladp_mem_model_inst.mem[8'h40] = 8'hF0;
		op_run(ALADP_OP_CONJ_MEM, 8'h40, 8'h00, 8'hA5, 4'b1001, 1'b1, 8'hA0);
		reg_rd(ALADP_REG_FLAGS, 32'h0000_0009);
	endtask
	// memory-target op followed at once by an immediate AND
	task automatic t_b2b;
		aladp_mem_model_inst.mem[8'h50] = 8'h0F;
		@(posedge i_clk);
		i_op_valid <= 1'b1;
		i_op_code <= ALADP_OP_CONJ_MEM;
		i_mem_addr <= 8'h50;
		@(posedge i_clk);
		i_op_code <= ALADP_OP_AND_ACC_IMM;
		i_imm <= 8'h0F;
		#1 `CHK("b2b_we", 1'b1, o_mem_we)
		`CHK("b2b_wdata", 8'h05, o_mem_wdata)
		@(posedge i_clk);
		i_op_valid <= 1'b0;
		#1 `CHK("b2b_work", 8'h05, o_work)
		`CHK("b2b_flags", 4'b1001, o_flags)
		`CHK("b2b_we_off", 1'b0, o_mem_we)
		`CHK("b2b_byte", 8'h05, aladp_mem_model_inst.mem[8'h50])
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1 t_reset();
		t_sum();
		t_and();
		t_conj();
		t_b2b();
		end_sim();
	end
	// about 45 cycles are needed; a hang past 2000 cycles is cut short
	initial begin
		#20000;
		n_errors++;
		end_sim();
	end
endmodule // tb
